/* pmbc_ctrl.sv */
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pmbc_map.svh"
// Function
// - Set fixed monitor flag while fixed detector reports low supply.
// - Software picks one of four levels; selectable flag sets at it.
// - Flag plus both enables raises system flag irq in run or idle.
// - Selectable irq wakes power-down only with awake bit set.
// - Fixed reset enable makes fixed event reset in run or idle; flag stays as cause.
// - Selectable reset enable resets; in power-down only when awake.
// - Clearing selectable enable stops its flag, irq and reset.
// - Nonzero divider field runs CPU at reduced rate.
// - Clock source select can pick low-speed internal oscillator.
// - Nonstop watchdog overflow in power-down sets flag and wakes.
// - Awake monitor keeps watching in power-down, sets flag, wakes.
// - Idle stops CPU clock only; peripherals keep clocks.
// - Idle keeps peripherals; counter array, watchdog only if set.
// - Enabled interrupt or reset ends idle, irq serviced at once.
// - Power-down stops oscillator and flash power, keeps RAM.
// - Power-down ends only on the listed wake sources.
// - In power-down enabled edge ext irqs act as level.
// - Interrupt wake restarts oscillator, gates CPU clock until full.
// - Reset pin rise exits power-down with the timed restart.
// - Keypad match with keypad irq enabled wakes with timed restart.
// - Level code 00 2.0V, 01 2.4V, 10 3.7V, 11 4.2V.
// - Status flags set by hardware, cleared by writing one.
module pmbc_ctrl
  import pmbc_pkg::*;
#(
  parameter int WAKE_CYCLES = `PMBC_WAKE_CYC
) (
  input  wire logic        CLOCK,
  input  wire logic        RST_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        FIXED_SUPPLY_MONITOR_LOW,
  input  wire logic        SELECTABLE_SUPPLY_MONITOR_LOW,
  input  wire logic        EXT_IRQ_PIN_A,
  input  wire logic        EXT_IRQ_PIN_B,
  input  wire logic        EXT_IRQ_PIN_C,
  input  wire logic        EXT_IRQ_PIN_D,
  input  wire logic        RST_PIN,
  input  wire logic        KEYPAD_MATCH,
  input  wire logic        RTC_OVERFLOW,
  input  wire logic        WATCHDOG_OVERFLOW,
  input  wire logic        IRQ_PENDING,
  output logic             CPU_CLK_EN,
  output logic             PERIPH_CLK_EN,
  output logic             OSC_EN,
  output logic             FLASH_PWR_EN,
  output logic             SELECTABLE_MONITOR_ON,
  output logic [1:0]       MONITOR_LEVEL_SELECT,
  output logic [2:0]       SYSTEM_CLOCK_DIVIDER,
  output logic [1:0]       CLOCK_SOURCE_SELECT,
  output logic             LOW_SPEED,
  output logic             WATCHDOG_RUN,
  output logic             COUNTER_ARRAY_RUN,
  output logic [3:0]       EXT_IRQ_LEVEL_FORCE,
  output logic             SYS_FLAG_IRQ,
  output logic             SYS_RESET_REQ,
  output logic             WAKE_IRQ
);
  // ==========================================================
  // Declarations
  pmbc_state_e  st_q, st_d;
  logic [9:0]   meta_q, sync_q, prev_q;
  logic [2:0]   flag_q;
  logic [7:0]   mon_q;
  logic [3:0]   ien_q;
  logic [5:0]   clk_q;
  logic [17:0]  wake_q;
  logic         rst_pend_q;
  logic         irq_q, rstreq_q, wakeirq_q;
  logic [31:0]  rdata_q;
  logic         wr, rd, hit;
  logic         fix_s, sel_s, rstp_s, kp_s, rtc_s, wdt_rise, rstp_rise;
  logic [3:0]   ext_s, ext_act;
  logic         in_pd, run_idle, sel_active;
  logic         fix_evt, sel_evt, wdt_evt, rst_evt;
  logic         irq_cond, pd_wake, idle_exit;
  logic [2:0]   flag_set, flag_clr;
  pmbc_wake_if  wk ();

  // Sticky flag: a set wins over a clear in the same cycle
  function automatic logic sticky(input logic f, input logic s,
                                  input logic c);
    sticky = s | (f & ~c);
  endfunction : sticky

  // ==========================================================
  // Pin synchronisers, two stages then edge history
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      meta_q <= 10'h000;
      sync_q <= 10'h000;
      prev_q <= 10'h000;
    end else begin
      meta_q <= {WATCHDOG_OVERFLOW, RTC_OVERFLOW, KEYPAD_MATCH, RST_PIN,
                 EXT_IRQ_PIN_D, EXT_IRQ_PIN_C, EXT_IRQ_PIN_B,
                 EXT_IRQ_PIN_A, SELECTABLE_SUPPLY_MONITOR_LOW,
                 FIXED_SUPPLY_MONITOR_LOW};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign fix_s     = sync_q[0];
  assign sel_s     = sync_q[1];
  assign ext_s     = sync_q[5:2];
  assign rstp_s    = sync_q[6];
  assign kp_s      = sync_q[7];
  assign rtc_s     = sync_q[8];
  assign wdt_rise  = sync_q[9] & ~prev_q[9];
  assign rstp_rise = rstp_s & ~prev_q[6];

  // ==========================================================
  // Event decode
  assign in_pd      = (st_q == PMBC_ST_PD) || (st_q == PMBC_ST_WAKE);
  assign run_idle   = !in_pd;
  assign sel_active = mon_q[`PMBC_MON_SEN] &
                      (run_idle | mon_q[`PMBC_MON_AWAKE]);
  assign fix_evt    = fix_s;
  assign sel_evt    = sel_s & sel_active;
  assign wdt_evt    = wdt_rise & (run_idle | wake_q[`PMBC_WK_NSW]);
  assign rst_evt    = (mon_q[`PMBC_MON_FRST] & fix_evt & run_idle) |
                      (mon_q[`PMBC_MON_SRST] & sel_evt) |
                      (wake_q[`PMBC_WK_WRST] & wdt_evt);
  assign irq_cond   = ien_q[`PMBC_IEN_SYS] & |(flag_q & ien_q[2:0]);

  // Level form of each ext pin, edge modes forced to level
  assign ext_act = wake_q[3:0] &
                   (wake_q[11:8] ~^ ext_s);

  // Power-down ends on listed sources only
  assign pd_wake = |ext_act | rstp_rise |
                   (wake_q[`PMBC_WK_KP] & kp_s) |
                   (wake_q[`PMBC_WK_RTC] & rtc_s) |
                   (sel_evt & ien_q[`PMBC_IEN_SYS] &
                    ien_q[`PMBC_FLG_SEL]) |
                   (wdt_evt & ien_q[`PMBC_IEN_SYS] &
                    ien_q[`PMBC_FLG_WDT]) |
                   rst_evt;
  assign idle_exit = IRQ_PENDING | irq_cond | rst_evt | rstp_s;

  // ==========================================================
  // APB decode: zero wait states, error on unmapped offsets
  assign wr  = PSEL & PENABLE & PWRITE;
  assign rd  = PSEL & ~PENABLE & ~PWRITE;
  assign hit = (PADDR[1:0] == 2'h0) && (PADDR <= `PMBC_OFS_STAT);
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~hit;
  assign PRDATA  = rdata_q;

  // Read data captured in the setup phase
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd) begin
      case (PADDR)
        `PMBC_OFS_MODE: rdata_q <= {30'h0, st_q == PMBC_ST_PD,
                                    st_q == PMBC_ST_IDLE};
        `PMBC_OFS_FLAG: rdata_q <= {29'h0, flag_q};
        `PMBC_OFS_MON:  rdata_q <= {24'h0, mon_q};
        `PMBC_OFS_IEN:  rdata_q <= {28'h0, ien_q};
        `PMBC_OFS_CLK:  rdata_q <= {26'h0, clk_q};
        `PMBC_OFS_WAKE: rdata_q <= {14'h0, wake_q};
        `PMBC_OFS_STAT: rdata_q <= {27'h0, rst_pend_q, st_q,
                                    sel_s, fix_s};
        default:        rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // Configuration registers
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      mon_q  <= `PMBC_MON_RST;
      ien_q  <= 4'h0;
      clk_q  <= 6'h00;
      wake_q <= 18'h00000;
    end else if (wr) begin
      if (PADDR == `PMBC_OFS_MON) begin
        mon_q <= (PWDATA[7:0] & `PMBC_MON_WMASK) | `PMBC_MON_FIXED;
      end
      if (PADDR == `PMBC_OFS_IEN) begin
        ien_q <= PWDATA[3:0];
      end
      if (PADDR == `PMBC_OFS_CLK) begin
        clk_q <= PWDATA[5:0] & `PMBC_CLK_WMASK;
      end
      if (PADDR == `PMBC_OFS_WAKE) begin
        wake_q <= PWDATA[17:0];
      end
    end
  end

  // ==========================================================
  // Status flags: hardware sets, write one clears
  assign flag_set = {sel_evt, fix_evt, wdt_evt};
  assign flag_clr = (wr && PADDR == `PMBC_OFS_FLAG) ? PWDATA[2:0] : 3'h0;

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      flag_q <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        flag_q[i] <= sticky(flag_q[i], flag_set[i], flag_clr[i]);
      end
    end
  end

  // ==========================================================
  // Mode machine
  always_comb begin
    st_d     = st_q;
    wk.start = 1'b0;
    case (st_q)
      PMBC_ST_RUN: begin
        if (wr && PADDR == `PMBC_OFS_MODE) begin
          if (PWDATA[`PMBC_MODE_PD]) begin
            st_d = PMBC_ST_PD;
          end else if (PWDATA[`PMBC_MODE_IDLE]) begin
            st_d = PMBC_ST_IDLE;
          end
        end
      end
      PMBC_ST_IDLE: begin
        if (idle_exit) begin
          st_d = PMBC_ST_RUN;
        end
      end
      PMBC_ST_PD: begin
        if (pd_wake) begin
          st_d     = PMBC_ST_WAKE;
          wk.start = 1'b1;
        end
      end
      PMBC_ST_WAKE: begin
        if (wk.done) begin
          st_d = PMBC_ST_RUN;
        end
      end
      default: st_d = PMBC_ST_RUN;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      st_q <= PMBC_ST_RUN;
    end else begin
      st_q <= st_d;
    end
  end

  // Reset raised in power-down waits for the timeout
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      rst_pend_q <= 1'b0;
    end else if (in_pd && rst_evt) begin
      rst_pend_q <= 1'b1;
    end else if (wk.done) begin
      rst_pend_q <= 1'b0;
    end
  end

  // Interrupt, reset and wake strobes
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      irq_q     <= 1'b0;
      rstreq_q  <= 1'b0;
      wakeirq_q <= 1'b0;
    end else begin
      irq_q     <= irq_cond & run_idle;
      rstreq_q  <= (rst_evt & run_idle) |
                   (wk.done & rst_pend_q);
      wakeirq_q <= wk.done & ~rst_pend_q & ~rstp_s;
    end
  end

  pmbc_wake_timer #(
    .WAKE_CYCLES (WAKE_CYCLES)
  ) u_timer (
    .CLOCK (CLOCK),
    .RST_N (RST_N),
    .wk    (wk)
  );

  // ==========================================================
  // Clock, power and monitor controls
  assign CPU_CLK_EN    = (st_q == PMBC_ST_RUN);
  assign PERIPH_CLK_EN = run_idle;
  assign OSC_EN        = (st_q != PMBC_ST_PD);
  assign FLASH_PWR_EN  = run_idle;
  assign SELECTABLE_MONITOR_ON = sel_active;
  assign MONITOR_LEVEL_SELECT  = mon_q[`PMBC_MON_LVL +: 2];
  assign SYSTEM_CLOCK_DIVIDER  = clk_q[2:0];
  assign CLOCK_SOURCE_SELECT   = clk_q[5:4];
  assign LOW_SPEED     = (clk_q[2:0] != 3'h0);
  assign WATCHDOG_RUN  = (st_q == PMBC_ST_RUN) |
                         ((st_q == PMBC_ST_IDLE) &
                          wake_q[`PMBC_WK_WIDLE]) |
                         (in_pd & wake_q[`PMBC_WK_NSW]);
  assign COUNTER_ARRAY_RUN = (st_q == PMBC_ST_RUN) |
                         ((st_q == PMBC_ST_IDLE) &
                          wake_q[`PMBC_WK_PIDLE]);
  assign EXT_IRQ_LEVEL_FORCE = in_pd ? (wake_q[3:0] &
                         wake_q[7:4]) : 4'h0;
  assign SYS_FLAG_IRQ  = irq_q;
  assign SYS_RESET_REQ = rstreq_q;
  assign WAKE_IRQ      = wakeirq_q;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  property p_fix_flag;
    fix_s |=> flag_q[`PMBC_FLG_FIX];
  endproperty
  a_fix_flag: assert property (p_fix_flag)
    else $error("fixed monitor flag not set");

  property p_sel_off;
    (!mon_q[`PMBC_MON_SEN] && !flag_q[`PMBC_FLG_SEL] &&
     !(wr && PADDR == `PMBC_OFS_MON && PWDATA[`PMBC_MON_SEN])) |=>
      !flag_q[`PMBC_FLG_SEL] && !SELECTABLE_MONITOR_ON;
  endproperty
  a_sel_off: assert property (p_sel_off)
    else $error("disabled monitor still active");

  property p_sys_irq;
    (irq_cond && run_idle) |=> SYS_FLAG_IRQ;
  endproperty
  a_sys_irq: assert property (p_sys_irq)
    else $error("system flag irq missing");

  property p_fix_rst;
    (mon_q[`PMBC_MON_FRST] && fix_s && run_idle) |=>
      SYS_RESET_REQ ##1 flag_q[`PMBC_FLG_FIX];
  endproperty
  a_fix_rst: assert property (p_fix_rst)
    else $error("fixed monitor reset missing");

  property p_w1c;
    (flag_clr[`PMBC_FLG_WDT] && !wdt_evt) |=> !flag_q[`PMBC_FLG_WDT];
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("flag not cleared by write of one");

  property p_idle_clk;
    (st_q == PMBC_ST_IDLE) |-> !CPU_CLK_EN && PERIPH_CLK_EN && OSC_EN;
  endproperty
  a_idle_clk: assert property (p_idle_clk)
    else $error("idle clocks wrong");

  property p_pd_stay;
    (st_q == PMBC_ST_PD && !pd_wake) |=> st_q == PMBC_ST_PD && !OSC_EN;
  endproperty
  a_pd_stay: assert property (p_pd_stay)
    else $error("power-down left without wake source");

  property p_wake_gate;
    wk.start |=> !CPU_CLK_EN [*8];
  endproperty
  a_wake_gate: assert property (p_wake_gate)
    else $error("CPU clock ran during timeout");

  property p_wake_end;
    wk.done |=> CPU_CLK_EN && $past(st_q) == PMBC_ST_WAKE;
  endproperty
  a_wake_end: assert property (p_wake_end)
    else $error("CPU clock not released after timeout");

  property p_speed;
    (wr && PADDR == `PMBC_OFS_CLK && PWDATA[2:0] != 3'h0) |=> LOW_SPEED;
  endproperty
  a_speed: assert property (p_speed)
    else $error("divider write did not slow the CPU");

  c_idle: cover property ((st_q == PMBC_ST_IDLE) ##1 st_q == PMBC_ST_RUN);
  c_pdwk: cover property (wk.start ##[1:1000] WAKE_IRQ);
  c_rst:  cover property (SYS_RESET_REQ);
  c_kp:   cover property (st_q == PMBC_ST_PD && kp_s && pd_wake);
endmodule : pmbc_ctrl
`default_nettype wire

/* pmbc_map.svh */
`ifndef PMBC_MAP_SVH
`define PMBC_MAP_SVH
// ==========================================================
// Register offsets (byte addresses)
`define PMBC_OFS_MODE  8'h00
`define PMBC_OFS_FLAG  8'h04
`define PMBC_OFS_MON   8'h08
`define PMBC_OFS_IEN   8'h0C
`define PMBC_OFS_CLK   8'h10
`define PMBC_OFS_WAKE  8'h14
`define PMBC_OFS_STAT  8'h18
// ==========================================================
// Field positions
`define PMBC_MODE_IDLE 0
`define PMBC_MODE_PD   1
`define PMBC_FLG_WDT   0
`define PMBC_FLG_FIX   1
`define PMBC_FLG_SEL   2
`define PMBC_MON_FRST  1
`define PMBC_MON_SEN   2
`define PMBC_MON_SRST  3
`define PMBC_MON_LVL   4
`define PMBC_MON_AWAKE 7
`define PMBC_IEN_SYS   3
`define PMBC_WK_EDGE   4
`define PMBC_WK_HIGH   8
`define PMBC_WK_KP     12
`define PMBC_WK_RTC    13
`define PMBC_WK_NSW    14
`define PMBC_WK_WRST   15
`define PMBC_WK_WIDLE  16
`define PMBC_WK_PIDLE  17
// ==========================================================
// Reset values and write masks
`define PMBC_MON_RST   8'h05
`define PMBC_MON_WMASK 8'hBE
`define PMBC_MON_FIXED 8'h01
`define PMBC_CLK_WMASK 6'h37
// ==========================================================
// Encodings and timing
`define PMBC_LVL_2V0   2'h0
`define PMBC_LVL_2V4   2'h1
`define PMBC_LVL_3V7   2'h2
`define PMBC_LVL_4V2   2'h3
`define PMBC_SRC_LOSC  2'h2
`define PMBC_WAKE_CYC  1024
`endif

/* pmbc_pkg.sv */
// ==========================================================
// Types of the power mode controller
package pmbc_pkg;
  typedef enum logic [1:0] {
    PMBC_ST_RUN  = 2'b00,
    PMBC_ST_PD   = 2'b01,
    PMBC_ST_WAKE = 2'b11,
    PMBC_ST_IDLE = 2'b10
  } pmbc_state_e;
endpackage : pmbc_pkg

/* pmbc_wake_if.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Start and finish of the wake-up timeout
interface pmbc_wake_if;
  logic start;
  logic done;
  modport ctrl  (output start, input done);
  modport timer (input start, output done);
endinterface : pmbc_wake_if
`default_nettype wire

/* pmbc_wake_timer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pmbc_map.svh"
// ==========================================================
// Wake-up timer: counts the restarted oscillator to full
module pmbc_wake_timer #(
  parameter int WAKE_CYCLES = `PMBC_WAKE_CYC
) (
  input wire logic   CLOCK,
  input wire logic   RST_N,
  pmbc_wake_if.timer wk
);
  localparam int CW = $clog2(WAKE_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(WAKE_CYCLES - 1);

  logic          busy_q;
  logic [CW-1:0] cnt_q;

  // Count runs from start until full
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      busy_q <= 1'b0;
      cnt_q  <= '0;
    end else if (wk.start) begin
      busy_q <= 1'b1;
      cnt_q  <= '0;
    end else if (busy_q) begin
      cnt_q  <= cnt_q + CW'(1);
      if (cnt_q == LAST) begin
        busy_q <= 1'b0;
      end
    end
  end

  // Full count ends the timeout
  assign wk.done = busy_q && (cnt_q == LAST);
endmodule : pmbc_wake_timer
`default_nettype wire

/* pmbc_far_side.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Wake sources and supply monitors outside the controller
module pmbc_far_side #(
  parameter int HOLD = 16
) (
  input  wire logic       CLOCK,
  input  wire logic       RST_N,
  input  wire logic       go,
  input  wire logic [2:0] src,
  input  wire logic       cpu_run,
  output logic [3:0]      ext_irq_n,
  output logic            rst_pin,
  output logic            keypad,
  output logic            rtc,
  output logic            wdt_ovf,
  output logic            sel_low,
  output logic            fix_low
);
  logic [6:0] act_q;
  int         cnt_q;

  // Raise one source; hold it until the CPU runs, reset pin past timeout
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      act_q <= '0;
      cnt_q <= 0;
    end else if (go) begin
      act_q <= 7'h01 << src;
      cnt_q <= 0;
    end else if (act_q != '0) begin
      cnt_q <= cnt_q + 1;
      if (act_q[1] ? cnt_q > HOLD + 4 :
          cpu_run && cnt_q > 2) begin
        act_q <= '0;
      end
    end
  end

  // Interrupt pins are active low and idle high
  assign ext_irq_n = {3'h7, ~act_q[0]};
  assign rst_pin   = act_q[1];
  assign keypad    = act_q[2];
  assign rtc       = act_q[3];
  assign wdt_ovf   = act_q[4];
  assign sel_low   = act_q[5];
  assign fix_low   = act_q[6];
endmodule : pmbc_far_side
`default_nettype wire

/* power_mode_and_brownout_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pmbc_map.svh"
// ==========================================================
// Self-checking bench of the power mode controller
module power_mode_and_brownout_control_tb;
  localparam int W = 16;
  typedef struct packed {
    logic [7:0]  a;
    logic [31:0] w;
    logic [31:0] r;
    logic [9:0]  o;
  } pmbc_row_s;
  logic        clock, rst_n, psel, penable, pwrite, go, irq_pend, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  src, div;
  logic        pready, pslverr, cpu_clk_en, periph_clk_en, osc_en;
  logic        flash_pwr_en, sel_on, low_speed, wd_run, ca_run, sys_irq;
  logic        sys_rst, wake_irq, rst_pin, keypad, rtc, wdt_ovf;
  logic        sel_low, fix_low;
  logic [1:0]  lvl, csrc;
  logic [3:0]  force_lvl, ext_n;
  int          mismatches, comparisons, n;
  pmbc_row_s   rows [9] = '{
    '{8'h08, 32'h04, 32'h05, 10'h100}, '{8'h08, 32'h14, 32'h15, 10'h140},
    '{8'h08, 32'h24, 32'h25, 10'h180}, '{8'h08, 32'h74, 32'h35, 10'h1C0},
    '{8'h08, 32'h30, 32'h31, 10'h0C0}, '{8'h10, 32'h27, 32'h27, 10'h0FD},
    '{8'h10, 32'h08, 32'h00, 10'h0C0}, '{8'h1C, 32'hFF, 32'h00, 10'h2C0},
    '{8'h08, 32'h04, 32'h05, 10'h100}};

  pmbc_ctrl #(.WAKE_CYCLES(W)) i_pmbc_ctrl (
    .CLOCK(clock), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .FIXED_SUPPLY_MONITOR_LOW(fix_low),
    .SELECTABLE_SUPPLY_MONITOR_LOW(sel_low), .EXT_IRQ_PIN_A(ext_n[0]),
    .EXT_IRQ_PIN_B(ext_n[1]), .EXT_IRQ_PIN_C(ext_n[2]),
    .EXT_IRQ_PIN_D(ext_n[3]), .RST_PIN(rst_pin), .KEYPAD_MATCH(keypad),
    .RTC_OVERFLOW(rtc), .WATCHDOG_OVERFLOW(wdt_ovf), .IRQ_PENDING(irq_pend),
    .CPU_CLK_EN(cpu_clk_en), .PERIPH_CLK_EN(periph_clk_en), .OSC_EN(osc_en),
    .FLASH_PWR_EN(flash_pwr_en), .SELECTABLE_MONITOR_ON(sel_on),
    .MONITOR_LEVEL_SELECT(lvl), .SYSTEM_CLOCK_DIVIDER(div),
    .CLOCK_SOURCE_SELECT(csrc), .LOW_SPEED(low_speed), .WATCHDOG_RUN(wd_run),
    .COUNTER_ARRAY_RUN(ca_run), .EXT_IRQ_LEVEL_FORCE(force_lvl),
    .SYS_FLAG_IRQ(sys_irq), .SYS_RESET_REQ(sys_rst), .WAKE_IRQ(wake_irq));

  pmbc_far_side #(.HOLD(W)) i_pmbc_far_side (
    .CLOCK(clock), .RST_N(rst_n), .go(go), .src(src), .cpu_run(cpu_clk_en),
    .ext_irq_n(ext_n), .rst_pin(rst_pin), .keypad(keypad), .rtc(rtc),
    .wdt_ovf(wdt_ovf), .sel_low(sel_low), .fix_low(fix_low));

  // ==========================================================
  // Clock and hang guard
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    repeat (100000) @(posedge clock);
    mismatches++;
    final_report();
  end

  // ==========================================================
  // Shared tasks
  task final_report;
    $display("Comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk

  // One APB transfer: setup, then access until pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1 && k < 20) begin
      @(posedge clock);
      k++;
    end
    if (k >= 20) begin
      mismatches++;
      final_report();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function logic sig(input int k);
    case (k)
      0: sig = cpu_clk_en;
      1: sig = sys_rst;
      2: sig = wake_irq;
      default: sig = sys_irq;
    endcase
  endfunction : sig

  task wait_sig(input int k, input int lim);
    n = 0;
    while (sig(k) !== 1'b1 && n < lim) begin
      @(posedge clock);
      n++;
    end
    if (n >= lim) begin
      mismatches++;
      $display("[FAIL] %0t wait ran out", $time);
      final_report();
    end
  endtask : wait_sig

  task fire(input logic [2:0] s);
    @(posedge clock);
    src <= s;
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
  endtask : fire

  // Enter power-down, check it holds, wake with one source
  task pd(input logic [31:0] cfg, input logic [2:0] s, input int k,
          input logic [5:0] pexp);
    apb(1'b1, `PMBC_OFS_WAKE, cfg);
    apb(1'b1, `PMBC_OFS_MODE, 32'h2);
    repeat (3) @(posedge clock);
    chk(32'({osc_en, flash_pwr_en, cpu_clk_en}), 32'h0, "pd clocks");
    chk(32'({force_lvl, wd_run, sel_on}),
        32'(pexp), "pd setup");
    repeat (30) @(posedge clock);
    chk(32'(cpu_clk_en), 32'h0, "pd left early");
    fire(s);
    wait_sig(k, 300);
    chk(32'(n >= W), 32'h1, "wake too soon");
    repeat (400) @(posedge clock);
  endtask : pd

  // ==========================================================
  // Main sequence
  initial begin
    {rst_n, psel, penable, pwrite, go, irq_pend} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    src = 3'h0;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    apb(1'b0, `PMBC_OFS_MON, 32'h0);
    chk(rd, 32'h05, "monitor reset value");
    for (int i = 0; i < 9; i++) begin
      apb(1'b1, rows[i].a, rows[i].w);
      apb(1'b0, rows[i].a, 32'h0);
      chk(rd, rows[i].r, "readback");
      chk(32'({er, sel_on, lvl, div, csrc, low_speed}),
          32'(rows[i].o), "outs");
    end
    // Fixed monitor flag, interrupt and write-one clear
    apb(1'b1, `PMBC_OFS_IEN, 32'h0A);
    fire(3'h6);
    wait_sig(3, 20);
    apb(1'b0, `PMBC_OFS_FLAG, 32'h0);
    chk(rd, 32'h2, "fixed flag");
    apb(1'b1, `PMBC_OFS_FLAG, 32'h0);
    apb(1'b0, `PMBC_OFS_FLAG, 32'h0);
    chk(rd, 32'h2, "flag cleared by zero");
    apb(1'b1, `PMBC_OFS_FLAG, 32'h2);
    apb(1'b0, `PMBC_OFS_FLAG, 32'h0);
    chk(rd, 32'h0, "flag not cleared");
    chk(32'(sys_irq), 32'h0, "irq stuck");
    // Selectable monitor off, then on
    apb(1'b1, `PMBC_OFS_MON, 32'h00);
    fire(3'h5);
    repeat (8) @(posedge clock);
    apb(1'b0, `PMBC_OFS_FLAG, 32'h0);
    chk(rd, 32'h0, "disabled monitor flagged");
    apb(1'b1, `PMBC_OFS_MON, 32'h04);
    fire(3'h5);
    repeat (8) @(posedge clock);
    apb(1'b0, `PMBC_OFS_FLAG, 32'h0);
    chk(rd, 32'h4, "selectable flag");
    // Fixed monitor reset keeps its flag
    apb(1'b1, `PMBC_OFS_MON, 32'h06);
    fire(3'h6);
    wait_sig(1, 20);
    apb(1'b0, `PMBC_OFS_FLAG, 32'h0);
    chk(rd, 32'h6, "reset cause flag");
    apb(1'b1, `PMBC_OFS_FLAG, 32'h7);
    apb(1'b1, `PMBC_OFS_MON, 32'h04);
    apb(1'b1, `PMBC_OFS_IEN, 32'h00);
    // Idle and exit by pending interrupt
    apb(1'b1, `PMBC_OFS_WAKE, 32'h0);
    apb(1'b1, `PMBC_OFS_MODE, 32'h1);
    repeat (3) @(posedge clock);
    chk(32'({cpu_clk_en, periph_clk_en, ca_run}),
        32'h2, "idle");
    irq_pend <= 1'b1;
    wait_sig(0, 10);
    irq_pend <= 1'b0;
    // Power-down wake sources
    pd(32'h11, 3'h0, 2, 6'h04);
    pd(32'h2000, 3'h3, 2, 6'h00);
    pd(32'h1000, 3'h2, 2, 6'h00);
    pd(32'hC000, 3'h4, 1, 6'h02);
    apb(1'b0, `PMBC_OFS_FLAG, 32'h0);
    chk(rd, 32'h1, "watchdog flag");
    apb(1'b1, `PMBC_OFS_MON, 32'h84);
    apb(1'b1, `PMBC_OFS_IEN, 32'h0C);
    pd(32'h0, 3'h5, 2, 6'h01);
    apb(1'b1, `PMBC_OFS_MON, 32'h8C);
    pd(32'h0, 3'h5, 1, 6'h01);
    apb(1'b1, `PMBC_OFS_IEN, 32'h00);
    pd(32'h0, 3'h1, 0, 6'h01);
    final_report();
  end
endmodule : power_mode_and_brownout_control_tb
`default_nettype wire
